// [sim/dcpd_link_model.sv]
/*
 * Link-side bus engine model: runs the link clock only during reset and around a write
 * and presents one complete decoded write per strobe.
 * Assumes the caller leaves the update sequencer time between writes.
 */
`timescale 1ns/1ps
module dcpd_link_model (
    // Link clock and reset
    output logic       link_clk,
    output logic       link_rst,
    // Decoded write
    output logic       wr_stb,
    output logic       bcast,
    output logic [7:0] ctrl,
    output logic [7:0] msb,
    output logic [7:0] lsb
);
    initial begin
        link_clk = 1'b0;
        link_rst = 1'b1;
        wr_stb   = 1'b0;
        bcast    = 1'b0;
        ctrl     = 8'h00;
        msb      = 8'h00;
        lsb      = 8'h00;
    end

    task automatic tick();
        #16 link_clk = 1'b1;
        #16 link_clk = 1'b0;
    endtask

    // Reset over three edges, released just after a fourth
    task automatic reset();
        repeat (3) tick();
        #16 link_clk = 1'b1;
        #1 link_rst = 1'b0;
        #15 link_clk = 1'b0;
    endtask

    // Bytes held up to the sampling edge, then scrambled once released
    task automatic send(input logic [7:0] c, m, l, input logic b);
        #16 link_clk = 1'b1;
        #1 wr_stb = 1'b1;
        bcast = b;
        ctrl = c;
        msb = m;
        lsb = l;
        #15 link_clk = 1'b0;
        #16 link_clk = 1'b1;
        #1 wr_stb = 1'b0;
        bcast = ~b;
        ctrl = ~c;
        msb = ~m;
        lsb = ~l;
        #15 link_clk = 1'b0;
        repeat (3) tick();
    endtask
endmodule // dcpd_link_model

// [sim/testbench.sv]
/*
 * Self-checking bench for the channel register and power-down block.
 * Assumes the link model above drives the link side of the design.
 */
`timescale 1ns/1ps
module testbench;
    logic        CLOCK, SYS_RST, SUPPLY_LOW, LINK_CLK, LINK_RST;
    logic        LINK_WR_STB, LINK_BCAST, UPDATE_DONE;
    logic [7:0]  LINK_CTRL, LINK_MSB, LINK_LSB;
    logic [7:0]  RB_PD_BYTE, RB_HIGH_BYTE, RB_LOW_BYTE;
    logic [1:0]  RB_LEN;
    logic [39:0] CH_CODE;
    logic [3:0]  AMP_EN, TERM_1K_EN, TERM_100K_EN, OPEN_EN, OUT_VALID;
    logic [11:0] stg[4], outr[4];
    logic        pds[4], pdo[4], rbl;
    logic [1:0]  rbs;
    int          n_errors, samples_checked;

    dcpd_regs uut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
        .SUPPLY_LOW(SUPPLY_LOW), .LINK_CLK(LINK_CLK), .LINK_RST(LINK_RST),
        .LINK_WR_STB(LINK_WR_STB), .LINK_BCAST(LINK_BCAST),
        .LINK_CTRL(LINK_CTRL), .LINK_MSB(LINK_MSB), .LINK_LSB(LINK_LSB),
        .RB_PD_BYTE(RB_PD_BYTE), .RB_HIGH_BYTE(RB_HIGH_BYTE),
        .RB_LOW_BYTE(RB_LOW_BYTE), .RB_LEN(RB_LEN), .CH_CODE(CH_CODE),
        .AMP_EN(AMP_EN), .TERM_1K_EN(TERM_1K_EN),
        .TERM_100K_EN(TERM_100K_EN), .OPEN_EN(OPEN_EN),
        .OUT_VALID(OUT_VALID), .UPDATE_DONE(UPDATE_DONE));

    dcpd_link_model lnk (.link_clk(LINK_CLK), .link_rst(LINK_RST),
        .wr_stb(LINK_WR_STB), .bcast(LINK_BCAST), .ctrl(LINK_CTRL),
        .msb(LINK_MSB), .lsb(LINK_LSB));

    initial CLOCK = 1'b0;
    always #20 CLOCK = ~CLOCK;

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [39:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compares code, switch and readback outputs against the reference registers
    task automatic check_all();
        logic [39:0] ec;
        logic [3:0]  ea, e1, e2, eo;
        logic [11:0] r;
        for (int k = 0; k < 4; k++) begin
            ec[10*k +: 10] = outr[k][9:0];
            ea[k] = !pdo[k];
            e1[k] = pdo[k] && outr[k][11:10] == dcpd_pkg::PD_1K;
            e2[k] = pdo[k] && outr[k][11:10] == dcpd_pkg::PD_100K;
            eo[k] = pdo[k] && !e1[k] && !e2[k];
        end
        r = outr[rbs];
        chk("code", ec, CH_CODE);
        chk("amp", 40'(ea), 40'(AMP_EN));
        chk("term1k", 40'(e1), 40'(TERM_1K_EN));
        chk("term100k", 40'(e2), 40'(TERM_100K_EN));
        chk("open", 40'(eo), 40'(OPEN_EN));
        chk("rb_pd", 40'({r[11:10], dcpd_pkg::RB_FILL}), 40'(RB_PD_BYTE));
        chk("rb_hi", 40'(r[9:2]), 40'(RB_HIGH_BYTE));
        chk("rb_lo", 40'({r[1:0], 6'h00}), 40'(RB_LOW_BYTE));
        chk("rb_len", 40'(rbl ? 2'h3 : 2'h2), 40'(RB_LEN));
    endtask

    // Reference update, one write through staging and output registers
    task automatic wr(input logic [7:0] c, m, l, input logic b);
        int   s;
        logic ld;
        s = c[2:1];
        if (c[0]) begin
            stg[s][11:10] = m[7:6];
            pds[s] = 1'b1;
        end else begin
            stg[s] = {2'h0, m, l[7:6]};
            pds[s] = 1'b0;
        end
        rbs = c[2:1];
        rbl = c[0];
        ld = b || c[5:4] != dcpd_pkg::LD_STAGE;
        for (int k = 0; k < 4; k++) begin
            if (ld && (b || c[5] || k == s)) begin
                outr[k] = stg[k];
                pdo[k] = pds[k];
            end
        end
        fork
            lnk.send(c, m, l, b);
            begin
                for (int i = 0; i < 60 && ld && UPDATE_DONE !== 1'b1; i++)
                    @(negedge CLOCK);
                if (ld) chk("done", 40'h1, 40'(UPDATE_DONE));
            end
        join
        repeat (14) @(negedge CLOCK);
        check_all();
    endtask

    initial begin
        #300000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        SYS_RST = 1'b1;
        SUPPLY_LOW = 1'b0;
        rbs = 2'h0;
        rbl = 1'b0;
        for (int k = 0; k < 4; k++) begin
            stg[k] = dcpd_pkg::REG_RST;
            outr[k] = dcpd_pkg::REG_RST;
            pds[k] = 1'b0;
            pdo[k] = 1'b0;
        end
        fork
            lnk.reset();
            repeat (20) @(posedge CLOCK);
        join
        #1 SYS_RST = 1'b0;
        repeat (2) @(negedge CLOCK);
        check_all();
        chk("valid", 40'hf, 40'(OUT_VALID));
        // Distinct codes per channel, full-scale code on ch0
        wr({4'h1, 1'b0, 2'd0, 1'b0}, 8'hff, 8'hc0, 1'b0);
        wr({4'h1, 1'b0, 2'd1, 1'b0}, 8'h00, 8'h40, 1'b0);
        wr({4'h1, 1'b0, 2'd2, 1'b0}, 8'ha5, 8'h80, 1'b0);
        wr({4'h1, 1'b0, 2'd3, 1'b0}, 8'h5a, 8'h00, 1'b0);
        // Staged only, then broadcast loads all with mixed power-down
        wr({4'h0, 1'b0, 2'd2, 1'b0}, 8'h12, 8'hc0, 1'b0);
        wr({4'h0, 1'b0, 2'd3, 1'b1}, 8'h80, 8'hff, 1'b1);
        // Every termination code on one channel, code kept
        for (int p = 0; p < 4; p++)
            wr({4'h1, 1'b0, 2'd1, 1'b1}, {p[1:0], 6'h15}, 8'hff, 1'b0);
        // Stage power-down on ch0, load all with data on ch1
        wr({4'h0, 1'b0, 2'd0, 1'b1}, 8'h40, 8'h00, 1'b0);
        wr({4'h2, 1'b0, 2'd1, 1'b0}, 8'h33, 8'h40, 1'b0);
        chk("valid_pd", 40'h0, 40'(OUT_VALID[0]));
        wr({4'h3, 1'b0, 2'd0, 1'b0}, 8'h81, 8'h80, 1'b0);
        chk("wake5_early", 40'h0, 40'(OUT_VALID[0]));
        repeat (70) @(negedge CLOCK);
        chk("wake5_late", 40'h1, 40'(OUT_VALID[0]));
        @(posedge CLOCK);
        #1 SUPPLY_LOW = 1'b1;
        wr({4'h1, 1'b0, 2'd0, 1'b1}, 8'hc0, 8'h00, 1'b0);
        wr({4'h1, 1'b0, 2'd0, 1'b0}, 8'h81, 8'h80, 1'b0);
        repeat (56) @(negedge CLOCK);
        chk("wake3_early", 40'h0, 40'(OUT_VALID[0]));
        repeat (65) @(negedge CLOCK);
        chk("wake3_late", 40'h1, 40'(OUT_VALID[0]));
        report_and_stop();
    end
endmodule // testbench

// [verilog/dcpd_outstage.sv]
/*
 * Output stage switch decode for one channel: amplifier or termination.
 * Assumes pd_act and pd_code come from the channel output register.
 */
`timescale 1ns/1ps
module dcpd_outstage (
    input  wire logic       clk,
    input  wire logic       rst,
    // From output register
    input  wire logic       pd_act,
    input  wire logic [1:0] pd_code,
    input  wire logic [9:0] code_in,
    // To analog stage
    output logic [9:0]      code_out,
    output logic            amp_en,
    output logic            term_1k_en,
    output logic            term_100k_en,
    output logic            open_en
);
    // Code and switches move together
    always_ff @(posedge clk) begin
        if (rst) begin
            code_out     <= 10'h000;
            amp_en       <= 1'b1;
            term_1k_en   <= 1'b0;
            term_100k_en <= 1'b0;
            open_en      <= 1'b0;
        end else begin
            code_out     <= code_in;
            amp_en       <= ~pd_act;
            term_1k_en   <= pd_act && pd_code == dcpd_pkg::PD_1K;
            term_100k_en <= pd_act && pd_code == dcpd_pkg::PD_100K;
            open_en      <= pd_act && (pd_code == dcpd_pkg::PD_OPEN_A
                            || pd_code == dcpd_pkg::PD_OPEN_B);
        end
    end

    property p_onehot;
        @(posedge clk) disable iff (rst)
        $onehot({amp_en, term_1k_en, term_100k_en, open_en});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("output stage switches not exclusive");

    property p_term_map;
        @(posedge clk) disable iff (rst)
        pd_act |=> !amp_en && (term_1k_en == ($past(pd_code) == 2'h1));
    endproperty
    a_term_map: assert property (p_term_map)
        else $error("termination does not match code");
endmodule // dcpd_outstage

// [verilog/dcpd_pkg.sv]
/*
 * Shared constants and types for the quad converter channel register
 * and power-down control block.
 * Assumes a 25 MHz system clock; all users refer to names as dcpd_pkg::name.
 */
package dcpd_pkg;

    localparam int CH_NUM    = 4;
    localparam int CODE_W    = 10;
    localparam int REG_W     = 12;
    localparam int SEL_W     = 2;

    // Register field layout
    localparam int REG_PD_HI = 11;
    localparam int REG_PD_LO = 10;
    localparam logic [11:0] REG_RST = 12'h000;

    // Control byte layout
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_SEL_LO = 1;
    localparam int CTRL_SEL_HI = 2;
    localparam int CTRL_LD_LO  = 4;
    localparam int CTRL_LD_HI  = 5;

    // Data byte layout
    localparam int MSB_PD_HI = 7;
    localparam int MSB_PD_LO = 6;
    localparam int LSB_D_HI  = 7;
    localparam int LSB_D_LO  = 6;

    // Load selections
    localparam logic [1:0] LD_STAGE = 2'h0;
    localparam logic [1:0] LD_ONE   = 2'h1;
    localparam logic [1:0] LD_ALL   = 2'h2;
    localparam logic [1:0] LD_ALL_B = 2'h3;

    // Power-down terminations
    localparam logic [1:0] PD_OPEN_A = 2'h0;
    localparam logic [1:0] PD_1K     = 2'h1;
    localparam logic [1:0] PD_100K   = 2'h2;
    localparam logic [1:0] PD_OPEN_B = 2'h3;

    // Readback
    localparam logic [5:0] RB_FILL    = 6'h3f;
    localparam logic [1:0] RB_LEN_PD  = 2'h3;
    localparam logic [1:0] RB_LEN_DAT = 2'h2;

    // Timing
    localparam int CLK_KHZ      = 25000;
    localparam int WAKE_5V_NS   = 2500;
    localparam int WAKE_3V_NS   = 5000;
    localparam int WAKE_W       = 7;
    localparam logic [6:0] WAKE_5V_CYC =
        7'((WAKE_5V_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [6:0] WAKE_3V_CYC =
        7'((WAKE_3V_NS * CLK_KHZ + 999999) / 1000000);
    localparam int UPD_KSPS     = 188;
    localparam int UPD_CYC      = CLK_KHZ / UPD_KSPS;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STAGE  = 2'b01,
        ST_UPDATE = 2'b11
    } dcpd_state_t;

endpackage

// [verilog/dcpd_regs.sv]
/*
 * Per-channel staging and output registers with power-down control for a
 * quad 10-bit converter. Writes arrive already decoded from the serial
 * bus engine on the link clock; readback bytes are offered for it.
 * Assumes the bus engine drives link inputs synchronous to LINK_CLK.
 */
`timescale 1ns/1ps
module dcpd_regs (
    // System
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        SUPPLY_LOW,
    // Link write
    input  wire logic        LINK_CLK,
    input  wire logic        LINK_RST,
    input  wire logic        LINK_WR_STB,
    input  wire logic        LINK_BCAST,
    input  wire logic [7:0]  LINK_CTRL,
    input  wire logic [7:0]  LINK_MSB,
    input  wire logic [7:0]  LINK_LSB,
    // Readback
    output logic [7:0]       RB_PD_BYTE,
    output logic [7:0]       RB_HIGH_BYTE,
    output logic [7:0]       RB_LOW_BYTE,
    output logic [1:0]       RB_LEN,
    // Channel outputs
    output logic [39:0]      CH_CODE,
    output logic [3:0]       AMP_EN,
    output logic [3:0]       TERM_1K_EN,
    output logic [3:0]       TERM_100K_EN,
    output logic [3:0]       OPEN_EN,
    output logic [3:0]       OUT_VALID,
    output logic             UPDATE_DONE
);
    localparam int NCH = dcpd_pkg::CH_NUM;

    logic                  sup_meta_r;
    logic                  sup_sync_r;
    logic                  wr_pulse;
    logic                  wr_bcast;
    logic [7:0]            wr_ctrl;
    logic [7:0]            wr_msb;
    logic [7:0]            wr_lsb;
    dcpd_pkg::dcpd_state_t state_r;
    dcpd_pkg::dcpd_state_t state_nxt;
    logic [11:0]           stg_r [NCH];
    logic [NCH-1:0]        stg_pd_r;
    logic [11:0]           out_r [NCH];
    logic [NCH-1:0]        out_pd_r;
    logic [6:0]            wake_r [NCH];
    logic [NCH-1:0]        wake_go;
    logic [NCH-1:0]        upd_mask;
    logic [1:0]            sel;
    logic [1:0]            ld;
    logic                  pd_flag;
    logic [1:0]            rb_sel_r;
    logic                  rb_pd_r;

    assign sel     = wr_ctrl[dcpd_pkg::CTRL_SEL_HI:dcpd_pkg::CTRL_SEL_LO];
    assign ld      = wr_ctrl[dcpd_pkg::CTRL_LD_HI:dcpd_pkg::CTRL_LD_LO];
    assign pd_flag = wr_ctrl[dcpd_pkg::CTRL_PD_BIT];

    function automatic logic [3:0] ch_onehot(input logic [1:0] s);
        ch_onehot = 4'h1 << s;
    endfunction

    // Channels refreshed by one update step
    function automatic logic [3:0] load_mask(input logic [1:0] l,
                                             input logic [1:0] s,
                                             input logic       b);
        if (b || l == dcpd_pkg::LD_ALL || l == dcpd_pkg::LD_ALL_B) begin
            load_mask = 4'hf;
        end else if (l == dcpd_pkg::LD_ONE) begin
            load_mask = ch_onehot(s);
        end else begin
            load_mask = 4'h0;
        end
    endfunction

    assign upd_mask = load_mask(ld, sel, wr_bcast);

    // Supply level pin
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sup_meta_r <= 1'b0;
            sup_sync_r <= 1'b0;
        end else begin
            sup_meta_r <= SUPPLY_LOW;
            sup_sync_r <= sup_meta_r;
        end
    end

    dcpd_xfer u_xfer (
        .link_clk    (LINK_CLK),
        .link_rst    (LINK_RST),
        .link_wr_stb (LINK_WR_STB),
        .link_bcast  (LINK_BCAST),
        .link_ctrl   (LINK_CTRL),
        .link_msb    (LINK_MSB),
        .link_lsb    (LINK_LSB),
        .clk         (CLOCK),
        .rst         (SYS_RST),
        .wr_pulse    (wr_pulse),
        .wr_bcast    (wr_bcast),
        .wr_ctrl     (wr_ctrl),
        .wr_msb      (wr_msb),
        .wr_lsb      (wr_lsb)
    );

    // Sequencer: stage then update
    always_comb begin
        case (state_r)
            dcpd_pkg::ST_IDLE: begin
                state_nxt = wr_pulse ? dcpd_pkg::ST_STAGE : dcpd_pkg::ST_IDLE;
            end
            dcpd_pkg::ST_STAGE: begin
                state_nxt = dcpd_pkg::ST_UPDATE;
            end
            default: begin
                state_nxt = dcpd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_r <= dcpd_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign UPDATE_DONE = state_r == dcpd_pkg::ST_UPDATE;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // Staging register write
            always_ff @(posedge CLOCK) begin
                if (SYS_RST) begin
                    stg_r[g]    <= dcpd_pkg::REG_RST;
                    stg_pd_r[g] <= 1'b0;
                end else if (state_r == dcpd_pkg::ST_STAGE && sel == g) begin
                    stg_pd_r[g] <= pd_flag;
                    if (pd_flag) begin
                        stg_r[g][dcpd_pkg::REG_PD_HI:dcpd_pkg::REG_PD_LO] <=
                            wr_msb[dcpd_pkg::MSB_PD_HI:dcpd_pkg::MSB_PD_LO];
                    end else begin
                        stg_r[g] <= {2'h0, wr_msb,
                            wr_lsb[dcpd_pkg::LSB_D_HI:dcpd_pkg::LSB_D_LO]};
                    end
                end
            end

            // Output register update, code untouched by power-down
            always_ff @(posedge CLOCK) begin
                if (SYS_RST) begin
                    out_r[g]    <= dcpd_pkg::REG_RST;
                    out_pd_r[g] <= 1'b0;
                end else if (state_r == dcpd_pkg::ST_UPDATE && upd_mask[g]) begin
                    out_r[g]    <= stg_r[g];
                    out_pd_r[g] <= stg_pd_r[g];
                end
            end

            assign wake_go[g] = state_r == dcpd_pkg::ST_UPDATE &&
                                upd_mask[g] && out_pd_r[g] && !stg_pd_r[g];

            // Wake-up interval after leaving power-down
            always_ff @(posedge CLOCK) begin
                if (SYS_RST) begin
                    wake_r[g] <= 7'h00;
                end else if (wake_go[g]) begin
                    wake_r[g] <= sup_sync_r ? dcpd_pkg::WAKE_3V_CYC
                                            : dcpd_pkg::WAKE_5V_CYC;
                end else if (wake_r[g] != 7'h00) begin
                    wake_r[g] <= wake_r[g] - 7'h01;
                end
            end

            always_ff @(posedge CLOCK) begin
                if (SYS_RST) begin
                    OUT_VALID[g] <= 1'b1;
                end else begin
                    OUT_VALID[g] <= !out_pd_r[g] && wake_r[g] == 7'h00 &&
                                    !wake_go[g];
                end
            end

            dcpd_outstage u_stage (
                .clk          (CLOCK),
                .rst          (SYS_RST),
                .pd_act       (out_pd_r[g]),
                .pd_code      (out_r[g][dcpd_pkg::REG_PD_HI:dcpd_pkg::REG_PD_LO]),
                .code_in      (out_r[g][dcpd_pkg::CODE_W-1:0]),
                .code_out     (CH_CODE[g*10 +: 10]),
                .amp_en       (AMP_EN[g]),
                .term_1k_en   (TERM_1K_EN[g]),
                .term_100k_en (TERM_100K_EN[g]),
                .open_en      (OPEN_EN[g])
            );
        end
    endgenerate

    // Readback channel follows the latest control byte
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rb_sel_r <= 2'h0;
            rb_pd_r  <= 1'b0;
        end else if (state_r == dcpd_pkg::ST_STAGE) begin
            rb_sel_r <= sel;
            rb_pd_r  <= pd_flag;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            RB_PD_BYTE   <= {2'h0, dcpd_pkg::RB_FILL};
            RB_HIGH_BYTE <= 8'h00;
            RB_LOW_BYTE  <= 8'h00;
            RB_LEN       <= dcpd_pkg::RB_LEN_DAT;
        end else begin
            RB_PD_BYTE   <= {out_r[rb_sel_r][dcpd_pkg::REG_PD_HI:
                                             dcpd_pkg::REG_PD_LO],
                             dcpd_pkg::RB_FILL};
            RB_HIGH_BYTE <= out_r[rb_sel_r][9:2];
            RB_LOW_BYTE  <= {out_r[rb_sel_r][1:0], 6'h00};
            RB_LEN       <= rb_pd_r ? dcpd_pkg::RB_LEN_PD
                                    : dcpd_pkg::RB_LEN_DAT;
        end
    end

    // Checks
    sequence s_stage_pd;
        state_r == dcpd_pkg::ST_STAGE && pd_flag;
    endsequence

    sequence s_stage_dat;
        state_r == dcpd_pkg::ST_STAGE && !pd_flag;
    endsequence

    property p_rst_zero;
        @(posedge CLOCK)
        SYS_RST |=> out_r[0] == 12'h000 && out_r[3] == 12'h000 &&
                    !out_pd_r[0];
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("output register not cleared by reset");

    property p_pd_take;
        @(posedge CLOCK) disable iff (SYS_RST)
        s_stage_pd |=> stg_r[$past(sel)][11:10] == $past(wr_msb[7:6]) &&
                       stg_pd_r[$past(sel)];
    endproperty
    a_pd_take: assert property (p_pd_take)
        else $error("power-down bits not staged");

    property p_pd_keep_code;
        @(posedge CLOCK) disable iff (SYS_RST)
        s_stage_pd |=> stg_r[$past(sel)][9:0] == $past(stg_r[sel][9:0]);
    endproperty
    a_pd_keep_code: assert property (p_pd_keep_code)
        else $error("staged code changed by power-down write");

    property p_dat_take;
        @(posedge CLOCK) disable iff (SYS_RST)
        s_stage_dat |=> !stg_pd_r[$past(sel)] &&
            stg_r[$past(sel)][9:2] == $past(wr_msb);
    endproperty
    a_dat_take: assert property (p_dat_take)
        else $error("plain data write not staged");

    property p_pulse_to_update;
        @(posedge CLOCK) disable iff (SYS_RST)
        state_r == dcpd_pkg::ST_IDLE && wr_pulse |=>
            state_r == dcpd_pkg::ST_STAGE ##1 UPDATE_DONE ##1
            state_r == dcpd_pkg::ST_IDLE;
    endproperty
    a_pulse_to_update: assert property (p_pulse_to_update)
        else $error("write not applied within three cycles");

    property p_all_load;
        @(posedge CLOCK) disable iff (SYS_RST)
        UPDATE_DONE && upd_mask == 4'hf |=>
            out_r[0] == $past(stg_r[0]) && out_r[1] == $past(stg_r[1]) &&
            out_pd_r == $past(stg_pd_r);
    endproperty
    a_all_load: assert property (p_all_load)
        else $error("simultaneous update missed a channel");

    property p_stage_only;
        @(posedge CLOCK) disable iff (SYS_RST)
        UPDATE_DONE && !wr_bcast && ld == dcpd_pkg::LD_STAGE |=>
            $stable(out_pd_r);
    endproperty
    a_stage_only: assert property (p_stage_only)
        else $error("output changed on stage-only load");

    sequence s_wake_hold;
        (!OUT_VALID[0]) [*8];
    endsequence

    property p_wake_5v;
        @(posedge CLOCK) disable iff (SYS_RST)
        wake_go[0] && !sup_sync_r |=>
            s_wake_hold ##56 !OUT_VALID[0] ##1 OUT_VALID[0];
    endproperty
    a_wake_5v: assert property (p_wake_5v)
        else $error("wake-up interval wrong");

    property p_wake_3v;
        @(posedge CLOCK) disable iff (SYS_RST)
        wake_go[0] && sup_sync_r |=>
            s_wake_hold ##118 !OUT_VALID[0] ##1 OUT_VALID[0];
    endproperty
    a_wake_3v: assert property (p_wake_3v)
        else $error("low supply wake-up interval wrong");

    property p_pd_invalid;
        @(posedge CLOCK) disable iff (SYS_RST)
        out_pd_r[1] |=> !OUT_VALID[1] && !AMP_EN[1];
    endproperty
    a_pd_invalid: assert property (p_pd_invalid)
        else $error("powered-down channel still active");

    property p_rb_fill;
        @(posedge CLOCK) disable iff (SYS_RST)
        rb_pd_r |=> RB_PD_BYTE[5:0] == 6'h3f && RB_LEN == 2'h3 &&
            RB_HIGH_BYTE == $past(out_r[rb_sel_r][9:2]);
    endproperty
    a_rb_fill: assert property (p_rb_fill)
        else $error("readback bytes wrong");
endmodule // dcpd_regs

// [verilog/dcpd_xfer.sv]
/*
 * Carries one decoded write (control, high and low data byte, broadcast)
 * from the link clock domain into the system clock domain.
 * Assumes writes come far apart compared to both clock periods.
 */
`timescale 1ns/1ps
module dcpd_xfer (
    // Link side
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       link_wr_stb,
    input  wire logic       link_bcast,
    input  wire logic [7:0] link_ctrl,
    input  wire logic [7:0] link_msb,
    input  wire logic [7:0] link_lsb,
    // System side
    input  wire logic       clk,
    input  wire logic       rst,
    output logic            wr_pulse,
    output logic            wr_bcast,
    output logic [7:0]      wr_ctrl,
    output logic [7:0]      wr_msb,
    output logic [7:0]      wr_lsb
);
    logic        tog_r;
    logic [24:0] hold_r;
    logic        meta_r;
    logic        sync_r;
    logic        prev_r;

    // Word is held still while the toggle crosses
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            tog_r  <= 1'b0;
            hold_r <= 25'h0;
        end else if (link_wr_stb) begin
            tog_r  <= ~tog_r;
            hold_r <= {link_bcast, link_ctrl, link_msb, link_lsb};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= tog_r;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pulse <= 1'b0;
            wr_bcast <= 1'b0;
            wr_ctrl  <= 8'h00;
            wr_msb   <= 8'h00;
            wr_lsb   <= 8'h00;
        end else begin
            wr_pulse <= sync_r ^ prev_r;
            if (sync_r ^ prev_r) begin
                {wr_bcast, wr_ctrl, wr_msb, wr_lsb} <= hold_r;
            end
        end
    end
endmodule // dcpd_xfer
